// ===== verilog/mcce_encoder.sv
`timescale 1ns/100ps
// Packs a detector report into a compound error code and logs it in a bank.
module mcce_encoder (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic fault_in,
    input wire mcce_pkg::mcce_class_e class_in,
    input wire logic [mcce_pkg::BANK_IDX_W-1:0] bank_sel_in,
    input wire logic access_known_in,
    input wire logic [1:0] access_kind_in,
    input wire logic level_known_in,
    input wire logic [1:0] cache_depth_in,
    input wire logic request_known_in,
    input wire logic instr_data_known_in,
    input wire logic [3:0] request_kind_in,
    input wire logic [1:0] role_field_in,
    input wire logic timed_out_in,
    input wire logic [1:0] space_field_in,
    input wire logic [mcce_pkg::NUM_BANKS-1:0] bank_clear_in,
    input wire logic [mcce_pkg::BANK_IDX_W-1:0] read_sel_in,
    output logic [15:0] bank_status_register_out,
    output logic entry_holds_info_out,
    output logic [15:0] last_code_out,
    output logic code_valid_out
);

    logic [1:0] access_kind;
    logic [1:0] cache_depth;
    logic [3:0] request_kind;
    logic [1:0] space_field;
    logic [15:0] code_next;
    logic [15:0] bank_code_reg [mcce_pkg::NUM_BANKS];
    logic [mcce_pkg::NUM_BANKS-1:0] bank_valid_reg;
    logic [15:0] last_code_reg;
    logic code_valid_reg;

    mcce_field_sanitizer u_sanitizer (
        .class_in(class_in),
        .access_known_in(access_known_in),
        .access_kind_in(access_kind_in),
        .level_known_in(level_known_in),
        .cache_depth_in(cache_depth_in),
        .request_known_in(request_known_in),
        .instr_data_known_in(instr_data_known_in),
        .request_kind_in(request_kind_in),
        .space_field_in(space_field_in),
        .access_kind_out(access_kind),
        .cache_depth_out(cache_depth),
        .request_kind_out(request_kind),
        .space_field_out(space_field)
    );

    // The role field is taken as seen by this processor, the one doing the logging.
    always_comb begin
        case (class_in)
            mcce_pkg::MCCE_CLASS_TLB: begin
                code_next = {mcce_pkg::TLB_PREFIX, access_kind, cache_depth};
            end
            mcce_pkg::MCCE_CLASS_CACHE: begin
                code_next = {mcce_pkg::CACHE_PREFIX, request_kind, access_kind,
                             cache_depth};
            end
            mcce_pkg::MCCE_CLASS_BUS: begin
                code_next = {mcce_pkg::BUS_PREFIX, role_field_in, timed_out_in, request_kind,
                             space_field, cache_depth};
            end
            mcce_pkg::MCCE_CLASS_TIMER: begin
                code_next = mcce_pkg::TIMER_CODE;
            end
            default: begin
                code_next = mcce_pkg::CODE_RESET;
            end
        endcase
    end

    // A new fault wins over a clear of the same bank in the same cycle.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bank_valid_reg <= '0;
            for (int i = 0; i < mcce_pkg::NUM_BANKS; i++) begin
                bank_code_reg[i] <= mcce_pkg::CODE_RESET;
            end
        end else begin
            for (int i = 0; i < mcce_pkg::NUM_BANKS; i++) begin
                if (fault_in && bank_sel_in == i[mcce_pkg::BANK_IDX_W-1:0]) begin
                    bank_code_reg[i] <= code_next;
                    bank_valid_reg[i] <= 1'b1;
                end else if (bank_clear_in[i]) begin
                    bank_code_reg[i] <= mcce_pkg::CODE_RESET;
                    bank_valid_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_code_reg <= mcce_pkg::CODE_RESET;
            code_valid_reg <= 1'b0;
        end else begin
            code_valid_reg <= fault_in;
            if (fault_in) begin
                last_code_reg <= code_next;
            end
        end
    end

    assign bank_status_register_out = bank_code_reg[read_sel_in];
    assign entry_holds_info_out = bank_valid_reg[read_sel_in];
    assign last_code_out = last_code_reg;
    assign code_valid_out = code_valid_reg;

endmodule // mcce_encoder

// ===== verilog/mcce_pkg.sv
package mcce_pkg;

    typedef enum logic [1:0] {
        MCCE_CLASS_TLB = 2'b00,
        MCCE_CLASS_CACHE = 2'b01,
        MCCE_CLASS_BUS = 2'b10,
        MCCE_CLASS_TIMER = 2'b11
    } mcce_class_e;

    localparam logic [1:0] ACCESS_INSTR = 2'h0;
    localparam logic [1:0] ACCESS_DATA = 2'h1;
    localparam logic [1:0] ACCESS_GENERIC = 2'h2;

    localparam logic [1:0] LEVEL_ZERO = 2'h0;
    localparam logic [1:0] LEVEL_ONE = 2'h1;
    localparam logic [1:0] LEVEL_TWO = 2'h2;
    localparam logic [1:0] LEVEL_ANY = 2'h3;

    localparam logic [3:0] REQ_GENERIC_FAULT = 4'h0;
    localparam logic [3:0] REQ_GENERIC_READ = 4'h1;
    localparam logic [3:0] REQ_GENERIC_WRITE = 4'h2;
    localparam logic [3:0] REQ_DATA_LOAD = 4'h3;
    localparam logic [3:0] REQ_DATA_STORE = 4'h4;
    localparam logic [3:0] REQ_INSTRUCTION_FETCH = 4'h5;
    localparam logic [3:0] REQ_PREFETCH = 4'h6;
    localparam logic [3:0] REQ_LINE_CASTOUT = 4'h7;
    localparam logic [3:0] REQ_SNOOP = 4'h8;

    localparam logic [1:0] ROLE_ORIGINATOR = 2'h0;
    localparam logic [1:0] ROLE_ANSWERED_REQUEST = 2'h1;
    localparam logic [1:0] ROLE_THIRD_PARTY_SEEN = 2'h2;
    localparam logic [1:0] ROLE_GENERIC = 2'h3;

    localparam logic [1:0] SPACE_MEMORY = 2'h0;
    localparam logic [1:0] SPACE_RESERVED = 2'h1;
    localparam logic [1:0] SPACE_IO = 2'h2;
    localparam logic [1:0] SPACE_OTHER = 2'h3;

    localparam logic [11:0] TLB_PREFIX = 12'h001;
    localparam logic [7:0] CACHE_PREFIX = 8'h01;
    localparam logic [4:0] BUS_PREFIX = 5'h01;
    localparam logic [15:0] TIMER_CODE = 16'h0400;

    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam int NUM_BANKS = 4;
    localparam int BANK_IDX_W = 2;

endpackage

// ===== verilog/mcce_field_sanitizer.sv
`timescale 1ns/100ps
// Forces the access, depth, request and space sub-fields to legal values before they are packed; role and expiry pass unchanged.
module mcce_field_sanitizer (
    input wire mcce_pkg::mcce_class_e class_in,
    input wire logic access_known_in,
    input wire logic [1:0] access_kind_in,
    input wire logic level_known_in,
    input wire logic [1:0] cache_depth_in,
    input wire logic request_known_in,
    input wire logic instr_data_known_in,
    input wire logic [3:0] request_kind_in,
    input wire logic [1:0] space_field_in,
    output logic [1:0] access_kind_out,
    output logic [1:0] cache_depth_out,
    output logic [3:0] request_kind_out,
    output logic [1:0] space_field_out
);

    function automatic logic is_write(input logic [3:0] kind);
        is_write = (kind == mcce_pkg::REQ_GENERIC_WRITE) || (kind == mcce_pkg::REQ_DATA_STORE);
    endfunction

    always_comb begin
        access_kind_out = access_kind_in;
        if (!access_known_in || access_kind_in == 2'h3) begin
            access_kind_out = mcce_pkg::ACCESS_GENERIC;
        end
    end

    always_comb begin
        cache_depth_out = cache_depth_in;
        if (!level_known_in) begin
            cache_depth_out = mcce_pkg::LEVEL_ANY;
        end
    end

    always_comb begin
        request_kind_out = request_kind_in;
        if (!request_known_in || request_kind_in > mcce_pkg::REQ_SNOOP) begin
            request_kind_out = mcce_pkg::REQ_GENERIC_FAULT;
        end else if (!instr_data_known_in) begin
            request_kind_out = is_write(request_kind_in) ? mcce_pkg::REQ_GENERIC_WRITE
                                                         : mcce_pkg::REQ_GENERIC_READ;
        end
        if (class_in != mcce_pkg::MCCE_CLASS_CACHE &&
            (request_kind_out == mcce_pkg::REQ_LINE_CASTOUT ||
             request_kind_out == mcce_pkg::REQ_SNOOP)) begin
            request_kind_out = mcce_pkg::REQ_GENERIC_FAULT;
        end
    end

    always_comb begin
        space_field_out = space_field_in;
        if (space_field_in == mcce_pkg::SPACE_RESERVED) begin
            space_field_out = mcce_pkg::SPACE_OTHER;
        end
    end

endmodule // mcce_field_sanitizer

// ===== tb/mcce_detector_model.sv
`timescale 1ns/100ps
// Stands in for the fault detectors; between reports it shows scrambled fields.
module mcce_detector_model (
    input wire logic fire_in,
    input wire logic [18:0] report_in,
    output logic fault_out,
    output logic [18:0] report_out
);
    always_comb begin
        fault_out = fire_in;
        report_out = fire_in ? report_in : ~report_in;
    end
endmodule // mcce_detector_model

// ===== tb/mcce_encoder_assertions.sv
`timescale 1ns/100ps
module mcce_encoder_assertions (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic fault_in,
    input wire mcce_pkg::mcce_class_e class_in,
    input wire logic level_known_in,
    input wire logic [3:0] request_kind_in,
    input wire logic [15:0] last_code_out,
    input wire logic code_valid_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_lone_fault;
        !fault_in ##1 fault_in ##1 !fault_in;
    endsequence
    sequence s_bus_fault;
        fault_in && class_in == mcce_pkg::MCCE_CLASS_BUS;
    endsequence
    a_pulse_follows_fault: assert property (fault_in |=> code_valid_out)
        else $error("no code pulse after fault");
    a_pulse_one_cycle: assert property (s_lone_fault |-> code_valid_out ##1 !code_valid_out)
        else $error("code pulse too long");
    a_timer_fixed_code: assert property (fault_in && class_in == mcce_pkg::MCCE_CLASS_TIMER
        |=> last_code_out == 16'h0400) else $error("bad timer code");
    a_tlb_prefix_form: assert property (fault_in && class_in == mcce_pkg::MCCE_CLASS_TLB
        |=> last_code_out[15:4] == 12'h001) else $error("bad tlb prefix");
    a_cache_prefix_form: assert property (fault_in && class_in == mcce_pkg::MCCE_CLASS_CACHE
        |=> last_code_out[15:8] == 8'h01) else $error("bad cache prefix");
    a_bus_prefix_form: assert property (s_bus_fault |=> last_code_out[15:11] == 5'h01)
        else $error("bad bus prefix");
    a_space_not_reserved: assert property (s_bus_fault |=> last_code_out[3:2] != 2'h1)
        else $error("reserved space code");
    a_bus_no_castout: assert property (s_bus_fault
        |=> last_code_out[7:4] != 4'h7 && last_code_out[7:4] != 4'h8)
        else $error("cache-only request on bus");
    a_generic_level: assert property (fault_in && !level_known_in
        && class_in != mcce_pkg::MCCE_CLASS_TIMER |=> last_code_out[1:0] == 2'h3)
        else $error("level not generic");
endmodule // mcce_encoder_assertions
bind mcce_encoder mcce_encoder_assertions u_chk (.*);

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic fire = 1'b0;
    logic [18:0] rep = 19'h00000;
    logic [1:0] bank = 2'h0;
    logic [3:0] clr = 4'h0;
    logic fault, bank_valid, code_valid;
    logic [18:0] rpt;
    logic [15:0] bank_code, last_code;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    // Row: class, known flags, access, depth, request, role, expiry, space, expected code.
    logic [34:0] rows [13] = '{
        {2'h0,4'hF,2'h1,2'h1,4'h0,2'h0,1'h0,2'h0,16'h0015}, {2'h0,4'h3,2'h0,2'h0,4'h0,2'h0,1'h0,2'h0,16'h001B},
        {2'h1,4'hF,2'h0,2'h2,4'h5,2'h0,1'h0,2'h0,16'h0152}, {2'h1,4'hF,2'h1,2'h0,4'h7,2'h0,1'h0,2'h0,16'h0174},
        {2'h1,4'hF,2'h2,2'h3,4'h8,2'h0,1'h0,2'h0,16'h018B}, {2'h1,4'hE,2'h1,2'h1,4'h4,2'h0,1'h0,2'h0,16'h0125},
        {2'h1,4'hD,2'h0,2'h0,4'h3,2'h0,1'h0,2'h0,16'h0100}, {2'h1,4'hF,2'h1,2'h2,4'h4,2'h0,1'h0,2'h0,16'h0146},
        {2'h2,4'hF,2'h0,2'h2,4'h3,2'h1,1'h1,2'h2,16'h0B3A}, {2'h2,4'hF,2'h0,2'h0,4'h7,2'h2,1'h0,2'h1,16'h0C0C},
        {2'h2,4'hF,2'h0,2'h1,4'h6,2'h3,1'h0,2'h0,16'h0E61}, {2'h2,4'hF,2'h0,2'h3,4'h1,2'h0,1'h1,2'h3,16'h091F},
        {2'h3,4'h0,2'h3,2'h1,4'hF,2'h3,1'h1,2'h1,16'h0400}};
    mcce_detector_model u_det (.fire_in(fire), .report_in(rep), .fault_out(fault),
        .report_out(rpt));
    mcce_encoder uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .fault_in(fault),
        .class_in(mcce_pkg::mcce_class_e'(rpt[18:17])), .bank_sel_in(bank),
        .access_known_in(rpt[16]), .level_known_in(rpt[15]), .request_known_in(rpt[14]),
        .instr_data_known_in(rpt[13]), .access_kind_in(rpt[12:11]),
        .cache_depth_in(rpt[10:9]), .request_kind_in(rpt[8:5]), .role_field_in(rpt[4:3]),
        .timed_out_in(rpt[2]), .space_field_in(rpt[1:0]), .bank_clear_in(clr),
        .read_sel_in(bank), .bank_status_register_out(bank_code),
        .entry_holds_info_out(bank_valid), .last_code_out(last_code),
        .code_valid_out(code_valid));
    initial forever #5 ref_clk_in = ~ref_clk_in;
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Presents a report for one edge; hold keeps the fault line up for a following report.
    task automatic fire_row(input logic [18:0] r, input logic [1:0] b, input logic hold);
        rep = r;
        bank = b;
        fire = 1'b1;
        @(negedge ref_clk_in);
        if (!hold) begin
            fire = 1'b0;
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 500) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(negedge ref_clk_in);
        check({code_valid, bank_valid, bank_code}, 18'h00000);
        rst_n_in = 1'b1;
        foreach (rows[i]) begin
            fire_row(rows[i][34:16], 2'(i), 1'b0);
            check({code_valid, bank_valid, bank_code}, {2'h3, rows[i][15:0]});
            check({2'h0, last_code}, {2'h0, rows[i][15:0]});
            @(negedge ref_clk_in);
            check({17'h0, code_valid}, 18'h00000);
            $display("row %0d done", i);
        end
        clr = 4'h1;
        fire_row(rows[2][34:16], 2'h0, 1'b1);
        check({code_valid, bank_valid, bank_code}, {2'h3, rows[2][15:0]});
        clr = 4'h0;
        fire_row(rows[8][34:16], 2'h0, 1'b0);
        check({code_valid, bank_valid, bank_code}, {2'h3, rows[8][15:0]});
        $display("back to back done");
        clr = 4'h1;
        @(negedge ref_clk_in);
        clr = 4'h0;
        check({code_valid, bank_valid, bank_code}, 18'h00000);
        check({2'h0, last_code}, {2'h0, rows[8][15:0]});
        bank = 2'h3;
        @(negedge ref_clk_in);
        check({code_valid, bank_valid, bank_code}, {2'h1, rows[11][15:0]});
        rst_n_in = 1'b0;
        @(negedge ref_clk_in);
        check({code_valid, bank_valid, bank_code}, 18'h00000);
        check({2'h0, last_code}, 18'h00000);
        rst_n_in = 1'b1;
        fire_row(rows[12][34:16], 2'h3, 1'b0);
        check({code_valid, bank_valid, bank_code}, {2'h3, rows[12][15:0]});
        $display("clear and reset done");
        summarize();
    end
endmodule // tb_top
